// ---- inc/pmc_pkg.sv ----
`default_nettype none
// ****************************************************************
// Shared types and constants for the output macrocell array
// ****************************************************************
package pmc_pkg;
  // Array shape
  localparam int CELLS = 8; // Output macrocells
  localparam int PTS = 8; // Product terms per macrocell
  localparam int COLS = 16; // Array signals: 8 inputs and 8 feedback columns
  // Field positions
  localparam int PT_OE_IDX = 0; // Product term used as output enable
  localparam int OUTER_LO = 0; // Outermost cell whose column takes the clock pin
  localparam int OUTER_HI = 7; // Outermost cell whose column takes the enable pin
  localparam int INNER_LO = 3; // Innermost cells, output only in simple mode
  localparam int INNER_HI = 4;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00; // Macrocell registers after reset
  localparam logic [7:0] OE_N_RESET = 8'hFF; // All pins released after reset
  localparam logic [7:0] OUT_RESET = 8'h00;

  // Global mode of all macrocells
  typedef enum logic [1:0] {
    PMC_SIMPLE,
    PMC_COMPLEX,
    PMC_REGISTERED
  } pmc_mode_type;

  // Static architecture configuration
  typedef struct packed {
    logic sync_mode_select_bit; // Global: low selects registered mode
    logic global_arch_bit; // Global: with the select bit picks the mode
    logic [7:0] cell_io_config_bit; // Per cell: input or I/O use
    logic [7:0] cell_polarity_bit; // Per cell: high passes, low inverts
  } pmc_cfg_type;

  // Register preload path for test equipment
  typedef struct packed {
    logic en; // Load the registers this cycle
    logic [7:0] data; // Value to force
  } pmc_preload_type;

  // Decode the two global bits into a mode
  function automatic pmc_mode_type pmc_decode_mode(input logic sel, input logic arch);
    if (!sel) begin
      return PMC_REGISTERED;
    end else if (arch) begin
      return PMC_COMPLEX;
    end else begin
      return PMC_SIMPLE;
    end
  endfunction : pmc_decode_mode
endpackage : pmc_pkg
`default_nettype wire

// ---- rtl/pmc_macrocells.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmc_macrocells #(
  parameter int NUM_CELLS = 8, // Macrocells in the array
  parameter int PT_PER_CELL = 8 // Product terms per macrocell
) (
  input wire logic mclk, // 40 MHz system clock
  input wire logic srst, // Synchronous reset, active high
  input wire pmc_pkg::pmc_cfg_type cfg, // Static architecture bits
  input wire logic [63:0][31:0] and_conn, // Literal connections of each product term
  input wire logic [63:0] product_term_disable, // Forces a product term low
  input wire logic [7:0] in_pins, // Dedicated input pins
  input wire logic clk_pin, // Clock pin, sampled on mclk
  input wire logic oe_pin_n, // Common output-enable pin, active low
  input wire logic [7:0] io_in, // Level seen on each I/O pin
  input wire pmc_pkg::pmc_preload_type preload, // Register preload
  output logic [7:0] io_out, // Driven level of each I/O pin
  output logic [7:0] io_oe_n, // Low while the cell drives its pin
  output logic [7:0] reg_state, // Macrocell register contents
  output pmc_pkg::pmc_mode_type mode // Decoded global mode
);
  import pmc_pkg::*;

  // Refuse shapes the fixed array cannot serve
  if (NUM_CELLS != CELLS || PT_PER_CELL != PTS) begin : g_shape_check
    $error("pmc_macrocells supports only 8 cells of 8 product terms");
  end

  // ****************************************************************
  // Product term arithmetic
  // ****************************************************************
  // One product term: AND of every connected literal, low when disabled
  function automatic logic pt_eval(input logic [31:0] conn, input logic [31:0] lits, input logic dis);
    return !dis && (&(~conn | lits));
  endfunction : pt_eval

  pmc_mode_type mode_cur; // Mode decoded from the global bits
  logic [COLS-1:0] cols; // Array signals before true/complement split
  logic [31:0] lits; // True and complement literals
  logic [63:0] pt; // All product terms
  logic [7:0] sum8; // OR of all eight terms of a cell
  logic [7:0] sum7; // OR of the seven terms beside the enable term
  logic [7:0] pol_d; // Polarity-corrected logic value of each cell
  logic [7:0] fb; // Feedback column of each cell
  logic [7:0] reg_r; // Macrocell registers, read by the feedback routing
  logic [7:0] reg_nxt; // Next macrocell register contents

  // ****************************************************************
  // Feedback routing and AND-OR array
  // ****************************************************************
  // Routes pins or registers into the feedback columns by mode
  always_comb begin
    mode_cur = pmc_decode_mode(cfg.sync_mode_select_bit, cfg.global_arch_bit);
    fb = 8'h00;
    for (int i = 0; i < CELLS; i++) begin
      case (mode_cur)
        PMC_REGISTERED: begin
          // Clock and enable pins stay out of the array
          fb[i] = cfg.cell_io_config_bit[i] ? io_in[i] : reg_r[i];
        end
        PMC_COMPLEX: begin
          // Inner six cells feed back their own pin
          fb[i] = io_in[i];
        end
        default: begin
          // Simple mode: columns take the neighbour one step outward
          if (i > OUTER_LO && i <= INNER_LO) begin
            fb[i] = io_in[i-1];
          end else if (i >= INNER_HI && i < OUTER_HI) begin
            fb[i] = io_in[i+1];
          end
        end
      endcase
    end
    if (mode_cur != PMC_REGISTERED) begin
      // Outer columns carry the clock and enable pins as data
      fb[OUTER_LO] = clk_pin;
      fb[OUTER_HI] = oe_pin_n;
    end
    cols = {fb, in_pins};
    // Each column gives a true and a complement literal
    for (int k = 0; k < COLS; k++) begin
      lits[2*k] = cols[k];
      lits[2*k+1] = !cols[k];
    end
    // Evaluate every product term of the array
    for (int p = 0; p < 64; p++) begin
      pt[p] = pt_eval(and_conn[p], lits, product_term_disable[p]);
    end
    // Full sum and seven-term sum of each cell
    for (int i = 0; i < CELLS; i++) begin
      sum8[i] = |pt[8*i +: 8];
      sum7[i] = |pt[8*i+1 +: 7];
    end
  end

  // ****************************************************************
  // Macrocell registers
  // ****************************************************************
  logic clk_pin_q_r; // Clock pin one mclk ago
  logic clk_pin_q_nxt;
  logic clk_rise; // Rising edge of the clock pin

  // Next register contents: reset, preload, then clock pin edge
  always_comb begin
    clk_pin_q_nxt = clk_pin;
    clk_rise = clk_pin && !clk_pin_q_r;
    reg_nxt = reg_r;
    for (int i = 0; i < CELLS; i++) begin
      // Sum of eight terms for registered cells and in simple mode, seven for I/O cells and in complex mode
      pol_d[i] = (cfg.cell_io_config_bit[i] || mode_cur != PMC_REGISTERED) ? sum7[i] : sum8[i];
      if (mode_cur == PMC_SIMPLE) begin
        pol_d[i] = sum8[i];
      end
      pol_d[i] = cfg.cell_polarity_bit[i] ? pol_d[i] : !pol_d[i];
    end
    // Reset beats preload, preload beats the clock pin
    if (srst) begin
      reg_nxt = REG_RESET;
      clk_pin_q_nxt = 1'b0;
    end else if (preload.en) begin
      reg_nxt = preload.data;
    end else if (clk_rise && mode_cur == PMC_REGISTERED) begin
      // One common clock for every registered cell
      for (int i = 0; i < CELLS; i++) begin
        if (!cfg.cell_io_config_bit[i]) begin
          reg_nxt[i] = pol_d[i];
        end
      end
    end
  end

  // Registers the macrocell state
  always_ff @(posedge mclk) begin
    clk_pin_q_r <= clk_pin_q_nxt;
    reg_r <= reg_nxt;
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic [7:0] out_nxt; // Next pin levels
  logic [7:0] oe_n_nxt; // Next pin enables, low drives
  pmc_mode_type mode_nxt; // Next decoded mode

  // Output level and enable of every pin by mode
  always_comb begin
    mode_nxt = mode_cur;
    out_nxt = OUT_RESET;
    oe_n_nxt = OE_N_RESET;
    for (int i = 0; i < CELLS; i++) begin
      case (mode_cur)
        PMC_REGISTERED: begin
          if (!cfg.cell_io_config_bit[i]) begin
            out_nxt[i] = reg_r[i];
            oe_n_nxt[i] = oe_pin_n;
          end else begin
            out_nxt[i] = pol_d[i];
            oe_n_nxt[i] = !pt[8*i+PT_OE_IDX];
          end
        end
        PMC_COMPLEX: begin
          out_nxt[i] = pol_d[i];
          oe_n_nxt[i] = !pt[8*i+PT_OE_IDX];
        end
        default: begin
          out_nxt[i] = pol_d[i];
          // Inner cells are always outputs; others follow the cell bit
          if (i == INNER_LO || i == INNER_HI || !cfg.cell_io_config_bit[i]) begin
            oe_n_nxt[i] = 1'b0;
          end
        end
      endcase
    end
    // Reset releases every pin
    if (srst) begin
      out_nxt = OUT_RESET;
      oe_n_nxt = OE_N_RESET;
      mode_nxt = PMC_SIMPLE;
    end
  end

  // Registers the pin drivers and status
  always_ff @(posedge mclk) begin
    io_out <= out_nxt;
    io_oe_n <= oe_n_nxt;
    mode <= mode_nxt;
  end

  // Register contents are shown as they stand
  assign reg_state = reg_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Mode output follows the two global bits one clock later
  a_mode_decode: assert property (##1 !$past(srst) |->
    mode == pmc_decode_mode($past(cfg.sync_mode_select_bit), $past(cfg.global_arch_bit)))
    else $error("mode not decoded from global bits");
  // Simple outputs carry the eight-term sum through the polarity bit
  a_polarity_simple: assert property (mode_cur == PMC_SIMPLE |=>
    io_out == $past(cfg.cell_polarity_bit ~^ sum8) && pol_d == (cfg.cell_polarity_bit ~^ sum8))
    else $error("simple output polarity wrong");
  // Simple cells drive unless set as inputs; inner cells always drive
  a_simple_enable: assert property (mode_cur == PMC_SIMPLE |=>
    io_oe_n == $past(cfg.cell_io_config_bit & 8'hE7))
    else $error("simple enable wrong");
  // Registered mode keeps the clock and enable pins out of the outer columns
  a_reg_pins_out: assert property (mode_cur == PMC_REGISTERED |->
    fb[OUTER_LO] == (cfg.cell_io_config_bit[OUTER_LO] ? io_in[OUTER_LO] : reg_r[OUTER_LO])
    && fb[OUTER_HI] == (cfg.cell_io_config_bit[OUTER_HI] ? io_in[OUTER_HI] : reg_r[OUTER_HI]))
    else $error("clock or enable pin reached the array");
  // Registered cells follow the common enable pin
  a_common_enable: assert property (mode_cur == PMC_REGISTERED && !cfg.cell_io_config_bit[2] |=>
    io_oe_n[2] == $past(oe_pin_n))
    else $error("registered cell ignores common enable");
  // A clock pin rise loads the corrected sum into a registered cell
  a_reg_capture: assert property (mode_cur == PMC_REGISTERED && clk_rise && !preload.en
    && !cfg.cell_io_config_bit[1] |=> reg_r[1] == $past(pol_d[1]))
    else $error("register missed clock pin edge");
  // Without a clock pin rise or preload the registers hold
  a_reg_hold: assert property (!clk_rise && !preload.en |=> $stable(reg_r))
    else $error("register changed without clock pin edge");
  // An I/O cell in registered mode sums the seven terms beside its enable term
  a_io_seven: assert property (mode_cur == PMC_REGISTERED && cfg.cell_io_config_bit[5] |=>
    io_out[5] == $past(cfg.cell_polarity_bit[5] ~^ (|pt[41 +: 7])))
    else $error("I/O cell sum wrong");
  // Complex mode: outer columns carry the pins, inner cells feed back their own pin
  a_complex_cols: assert property (mode_cur == PMC_COMPLEX |->
    fb[OUTER_LO] == clk_pin && fb[OUTER_HI] == oe_pin_n && fb[3] == io_in[3])
    else $error("complex feedback routing wrong");
  // Complex mode: term zero enables the pin, terms one to seven form the sum
  a_complex_oe: assert property (mode_cur == PMC_COMPLEX |=>
    io_oe_n[6] == !$past(pt[48]) && io_out[6] == $past(cfg.cell_polarity_bit[6] ~^ (|pt[49 +: 7])))
    else $error("complex enable term wrong");
  // Simple mode: columns take the neighbour pin one step outward
  a_simple_adjacent: assert property (mode_cur == PMC_SIMPLE |->
    fb[1] == io_in[0] && fb[6] == io_in[7] && fb[INNER_LO] == io_in[2])
    else $error("simple feedback routing wrong");
  // A preload forces the register contents one clock later
  a_preload_load: assert property (preload.en |=> reg_state == $past(preload.data))
    else $error("preload not taken");
  // Reset leaves cleared registers and released pins
  a_reset_clear: assert property (@(posedge mclk) $past(srst) |->
    reg_state == REG_RESET && io_oe_n == OE_N_RESET && io_out == OUT_RESET)
    else $error("reset did not clear");
  // The architecture bits stay put while the logic runs
  a_config_static: assert property (##1 $stable(cfg))
    else $error("configuration changed while running");
  // Simple mode never feeds an inner pin back into the array
  a_simple_inner: assert property (mode_cur == PMC_SIMPLE |->
    fb[2] == io_in[1] && fb[INNER_HI] == io_in[5] && fb[5] == io_in[6])
    else $error("simple inner routing wrong");
  // Outside registered mode a clock pin rise leaves the registers alone
  a_reg_idle: assert property (mode_cur != PMC_REGISTERED && !preload.en |=> $stable(reg_r))
    else $error("register loaded outside registered mode");
  // An I/O cell in registered mode keeps its register unchanged
  a_io_no_reg: assert property (mode_cur == PMC_REGISTERED && cfg.cell_io_config_bit[6]
    && !preload.en |=> reg_r[6] == $past(reg_r[6]))
    else $error("I/O cell register loaded");
  // A registered cell drives its register value onto the pin
  a_reg_output: assert property (mode_cur == PMC_REGISTERED && !cfg.cell_io_config_bit[0] |=>
    io_out[0] == $past(reg_r[0]))
    else $error("registered output wrong");
  // An I/O cell in registered mode takes its enable from term zero
  a_io_enable: assert property (mode_cur == PMC_REGISTERED && cfg.cell_io_config_bit[6] |=>
    io_oe_n[6] == !$past(pt[48]))
    else $error("I/O cell enable wrong");
  // Complex mode keeps the polarity bit on cell one
  a_complex_polarity: assert property (mode_cur == PMC_COMPLEX |=>
    io_out[1] == $past(cfg.cell_polarity_bit[1] ~^ (|pt[9 +: 7])))
    else $error("complex polarity wrong");

  // Two clock pin rises with idle clocks between
  c_registered_run: cover property (mode_cur == PMC_REGISTERED && clk_rise ##1 !clk_rise [*3] ##1 clk_rise);
  // A complex cell released by its enable term
  c_complex_io: cover property (mode_cur == PMC_COMPLEX ##1 !io_oe_n[5] ##1 io_oe_n[5]);
  // An inner simple output rising
  c_simple_out: cover property (mode_cur == PMC_SIMPLE ##1 $rose(io_out[3]));
  // A preload followed by a clock pin rise
  c_preload_use: cover property (preload.en ##1 mode_cur == PMC_REGISTERED && clk_rise);
  // Every pin driven under the common enable
  c_common_drive: cover property (mode_cur == PMC_REGISTERED ##1 io_oe_n == 8'h00);
endmodule : pmc_macrocells
`default_nettype wire

// ---- testbench/pmc_board.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Board logic on the far side of the I/O pins
// ****************************************************************
module pmc_board (
  input wire logic [7:0] io_out, // Levels the cells drive
  input wire logic [7:0] io_oe_n, // Low where a cell drives its pin
  input wire logic [7:0] board_val, // Level the board puts on released pins
  output logic [7:0] io_in // Resolved pin level seen by the array
);
  // A driven pin shows the cell, a released pin the board's own level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      io_in[i] = io_oe_n[i] ? board_val[i] : io_out[i];
    end
  end
endmodule : pmc_board
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench for the macrocell array
// ****************************************************************
module tb;
  import pmc_pkg::*;
  localparam pmc_mode_type MEXP [4] = '{PMC_REGISTERED, PMC_REGISTERED, PMC_SIMPLE, PMC_COMPLEX};
  logic mclk, srst, clk_pin, oe_pin_n;
  pmc_cfg_type cfg;
  logic [63:0][31:0] and_conn;
  logic [63:0] product_term_disable;
  logic [7:0] in_pins, io_in, board_val, io_out, io_oe_n, reg_state;
  pmc_preload_type preload;
  pmc_mode_type mode;
  int miscompares, comparisons;

  pmc_macrocells i_pmc_macrocells (.mclk(mclk), .srst(srst), .cfg(cfg), .and_conn(and_conn),
    .product_term_disable(product_term_disable), .in_pins(in_pins), .clk_pin(clk_pin),
    .oe_pin_n(oe_pin_n), .io_in(io_in), .preload(preload), .io_out(io_out), .io_oe_n(io_oe_n),
    .reg_state(reg_state), .mode(mode));
  pmc_board i_pmc_board (.io_out(io_out), .io_oe_n(io_oe_n), .board_val(board_val), .io_in(io_in));

  // Free-running 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task finish_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Load a configuration under reset, five clocks, with idle inputs
  task setup(input logic sel, input logic arch, input logic [7:0] cb, input logic [7:0] pol);
    cfg = '{sel, arch, cb, pol};
    and_conn = '0;
    product_term_disable = '0;
    in_pins = 8'h00;
    clk_pin = 1'b0;
    oe_pin_n = 1'b1;
    preload = '0;
    srst = 1'b1;
    cyc(5);
    srst = 1'b0;
    cyc(1);
  endtask : setup

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset clears a preloaded register and returns the pins to idle
  task t_reset;
    setup(1'b0, 1'b0, 8'h00, 8'hFF);
    preload = '{1'b1, 8'hA5};
    cyc(1);
    chk(reg_state, 8'hA5);
    preload = '0;
    srst = 1'b1;
    cyc(1);
    chk(reg_state, REG_RESET);
    chk(io_oe_n, OE_N_RESET);
    chk(io_out, OUT_RESET);
    chk(8'(mode), 8'(PMC_SIMPLE));
    srst = 1'b0;
    cyc(1);
  endtask : t_reset

  // Every pairing of the two global bits
  task t_modes;
    for (int i = 0; i < 4; i++) begin
      setup(i[1], i[0], 8'h00, 8'hFF);
      chk(8'(mode), 8'(MEXP[i]));
    end
  endtask : t_modes

  // Inverted cells, inner cells driven, feedback from the neighbour pin
  task t_simple;
    setup(1'b1, 1'b0, 8'hFF, 8'h0F);
    product_term_disable[23:17] = '1;
    and_conn[8] = 32'h0004_0000;
    product_term_disable[15:9] = '1;
    board_val = 8'h00;
    cyc(1);
    chk(io_out, 8'h0D);
    chk(io_oe_n, 8'hE7);
    board_val = 8'h01;
    cyc(1);
    chk(io_out, 8'h0F);
  endtask : t_simple

  // Enable term, seven sum terms, clock pin read as data
  task t_complex;
    setup(1'b1, 1'b1, 8'h00, 8'hFF);
    product_term_disable[40] = 1'b1;
    product_term_disable[23:17] = '1;
    and_conn[9] = 32'h0001_0000;
    product_term_disable[15:10] = '1;
    cyc(1);
    chk(io_oe_n, 8'h20);
    chk(io_out, 8'hF9);
    clk_pin = 1'b1;
    cyc(1);
    chk(io_out, 8'hFB);
  endtask : t_complex

  // Common enable, preload, clocked capture with feedback
  task t_registered;
    setup(1'b0, 1'b0, 8'h40, 8'hFF);
    and_conn[0] = 32'h0002_0000;
    product_term_disable[7:1] = '1;
    product_term_disable[31:25] = '1;
    cyc(1);
    chk(io_oe_n, 8'hBF);
    oe_pin_n = 1'b0;
    preload = '{1'b1, 8'h1A};
    cyc(1);
    preload = '0;
    chk(io_oe_n, 8'h00);
    chk(reg_state, 8'h1A);
    clk_pin = 1'b1;
    cyc(2);
    chk(reg_state, 8'hBF);
    cyc(1);
    chk(io_out, 8'hFF);
    clk_pin = 1'b0;
    cyc(1);
    clk_pin = 1'b1;
    cyc(2);
    chk(reg_state, 8'hBE);
  endtask : t_registered

  // Main sequence
  initial begin
    miscompares = 0;
    comparisons = 0;
    board_val = 8'h00;
    setup(1'b1, 1'b0, 8'h00, 8'hFF);
    t_reset();
    t_modes();
    t_simple();
    t_complex();
    t_registered();
    finish_test();
  end
endmodule : tb
`default_nettype wire
